// file: verilog/toc_core.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Each phase uses its fundamental RMS current and the settings.
// - Per phase: pickup while started, trip once computed delay expires.
// - Phase pickups and trips merge into general pickup and trip.
// - Inhibit input disables the function, clearing pickups and trips.
// - Mode picks off, definite or eleven inverse curves; off by default.
// - Start threshold in percent, step 1, default 200.
// - Time multiplier in hundredths over its range.
// - Minimum inverse delay in ms, step 1, default 100.
// - Definite mode trips after its own ms delay, default 100.
// - Fixed IEC reset delay adjustable in ms steps.
// - Inverse time is TMS times the sum of k over ratio power minus one, and c.
// - Ratio above twenty is clamped to twenty.
// - Inverse delay is the larger of curve time and minimum delay.
// - IEC resets after fixed delay; ANSI after TMS kr over 1-ratio^2.
module toc_core #(
   parameter int unsigned TICK_CYCLES = toc_pkg::TICK_CYCLES
) (
   input wire logic core_clk, // 40 MHz processing clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic [15:0] phase1_fundamental_rms, // Phase 1, percent
   input wire logic [15:0] phase2_fundamental_rms, // Phase 2, percent
   input wire logic [15:0] phase3_fundamental_rms, // Phase 3, percent
   input wire logic inhibit_input, // High disables the function
   input wire logic [7:0] paddr, // APB byte address
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   output logic phase1_pickup, // Phase 1 started
   output logic phase2_pickup, // Phase 2 started
   output logic phase3_pickup, // Phase 3 started
   output logic phase1_trip, // Phase 1 trip
   output logic phase2_trip, // Phase 2 trip
   output logic phase3_trip, // Phase 3 trip
   output logic any_phase_pickup, // General pickup
   output logic any_phase_trip, // General trip
   output logic irq // Level interrupt
);
   toc_pkg::toc_cfg_t cfg_ff;
   toc_pkg::toc_seq_t seq_ff;
   toc_pkg::toc_curve_t crv;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff, irq_ff;
   logic [toc_pkg::EV_W-1:0] irq_stat_ff, irq_mask_ff, ev_prev_ff, ev_now;
   logic [2:0] pick_ff, trip_ff;
   logic gen_pick_ff, gen_trip_ff, tick_ff, active, is_ansi, is_iec;
   logic [15:0] tick_cnt_ff, ratio_ff;
   logic [15:0] meas [3];
   logic [15:0] op_cnt_ff [3];
   logic [15:0] rst_cnt_ff [3];
   logic [15:0] op_dly_ff [3];
   logic [15:0] rst_dly_ff [3];
   logic [15:0] rst_lim [3];
   logic [1:0] ph_ff;
   logic [47:0] div_num_ff, div_den_ff, div_quo_ff, div_rem_ff;
   logic [47:0] ld_num_ff, ld_den_ff, rem_sh;
   logic [5:0] div_cnt_ff;
   logic div_go_ff, div_done_ff;
   logic [31:0] rd_val, den_q16;
   logic rd_err, acc_first, acc_done, wr_en;
   logic [24:0] t01;
   logic [63:0] t_prod;
   logic [15:0] t_ms;

   // Approximate log2 of a Q8 ratio above one, result in Q8
   function automatic logic [15:0] log2_q8(input logic [15:0] r);
      logic [3:0] n;
      logic [15:0] frac;
      n = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (r[i]) n = 4'(i);
      end
      frac = (r & ~(16'h0001 << n)) >> (n - 4'h8);
      log2_q8 = ((16'(n) - 16'h0008) << 8) | frac;
   endfunction : log2_q8

   // Curve denominator in Q16, never zero so the divide stays bounded
   function automatic logic [31:0] curve_den(input logic [15:0] r,
                                             input logic [1:0] alpha);
      logic [31:0] sq, d;
      sq = 32'(r) * 32'(r);
      if (r < toc_pkg::RATIO_ONE) begin
         d = toc_pkg::Q16_ONE - sq;
      end else begin
         case (alpha)
            2'h1: d = {8'h00, r, 8'h00} - toc_pkg::Q16_ONE;
            2'h2: d = sq - toc_pkg::Q16_ONE;
            default: d = (32'(log2_q8(r)) * toc_pkg::LN_SCALE) >> 8;
         endcase
      end
      curve_den = (d == 32'h0000_0000) ? 32'h0000_0001 : d;
   endfunction : curve_den

   assign meas[0] = phase1_fundamental_rms;
   assign meas[1] = phase2_fundamental_rms;
   assign meas[2] = phase3_fundamental_rms;
   assign active = (cfg_ff.mode != toc_pkg::TOC_OFF) && !inhibit_input;
   assign is_ansi = cfg_ff.mode >= toc_pkg::TOC_ANSI_INV;
   assign is_iec = (cfg_ff.mode >= toc_pkg::TOC_IEC_INV) && !is_ansi;
   assign crv = toc_pkg::curve_of(cfg_ff.mode);
   assign den_q16 = curve_den(ratio_ff, crv.alpha);
   assign acc_first = psel && penable && !pready_ff;
   assign acc_done = psel && penable && pready_ff;
   assign wr_en = acc_done && pwrite;
   assign ev_now = {gen_trip_ff, gen_pick_ff, pick_ff};
   assign rem_sh = {div_rem_ff[46:0], div_num_ff[47]};

   // Reset time limit per phase: definite is immediate, IEC fixed, ANSI curve
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         if (is_ansi) rst_lim[p] = rst_dly_ff[p];
         else if (is_iec) rst_lim[p] = cfg_ff.rst_dly;
         else rst_lim[p] = 16'h0000;
      end
   end

   // Time scaling: quotient plus c when ratio exceeds one, times TMS, then 0.1 ms to ms
   always_comb begin
      t01 = (div_quo_ff[47:24] != 24'h0) ? 25'h0FFFFFF :
            {1'b0, div_quo_ff[23:0]};
      if (ratio_ff > toc_pkg::RATIO_ONE) t01 = t01 + 25'(crv.c);
      t_prod = (64'(t01) * 64'(cfg_ff.tms) * toc_pkg::RECIP_1000)
               >> toc_pkg::RECIP_SHIFT;
      t_ms = (t_prod[63:16] != 48'h0) ? 16'hFFFF : t_prod[15:0];
      if (t_ms == 16'h0000) t_ms = 16'h0001;
   end

   // Register read mux; misaligned and unmapped addresses flag an error
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      case (paddr)
         toc_pkg::OFS_MODE: rd_val = {28'h0, cfg_ff.mode};
         toc_pkg::OFS_START: rd_val = {16'h0, cfg_ff.start};
         toc_pkg::OFS_TMS: rd_val = {16'h0, cfg_ff.tms};
         toc_pkg::OFS_MIN_DLY: rd_val = {16'h0, cfg_ff.min_dly};
         toc_pkg::OFS_DEF_DLY: rd_val = {16'h0, cfg_ff.def_dly};
         toc_pkg::OFS_RST_DLY: rd_val = {16'h0, cfg_ff.rst_dly};
         toc_pkg::OFS_STATUS: rd_val = {24'h0, gen_trip_ff, gen_pick_ff,
                                        trip_ff, pick_ff};
         toc_pkg::OFS_IRQ_STAT: rd_val = {27'h0, irq_stat_ff};
         toc_pkg::OFS_IRQ_MASK: rd_val = {27'h0, irq_mask_ff};
         default: rd_err = 1'b1;
      endcase
   end

   // APB slave: one wait state, data and error staged with ready
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pready_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= acc_first;
         if (acc_first) begin
            prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr_ff <= rd_err;
         end else if (acc_done) begin
            pslverr_ff <= 1'b0;
         end
      end
   end

   // Settings; out-of-range values clamp so the timers stay sane, and an out-of-range mode write is ignored
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_ff <= toc_pkg::CFG_RST;
         irq_mask_ff <= '0;
      end else if (wr_en) begin
         case (paddr)
            toc_pkg::OFS_MODE: begin
               if (pwdata[3:0] <= toc_pkg::TOC_ANSI_LEXT)
                  cfg_ff.mode <= toc_pkg::toc_mode_t'(pwdata[3:0]);
            end
            toc_pkg::OFS_START: cfg_ff.start <= toc_pkg::clamp16(pwdata[15:0],
               toc_pkg::START_MIN, toc_pkg::START_MAX);
            toc_pkg::OFS_TMS: cfg_ff.tms <= toc_pkg::clamp16(pwdata[15:0],
               toc_pkg::TMS_MIN, toc_pkg::TMS_MAX);
            toc_pkg::OFS_MIN_DLY: cfg_ff.min_dly <= toc_pkg::clamp16(
               pwdata[15:0], toc_pkg::DLY_MIN, toc_pkg::DLY_MAX);
            toc_pkg::OFS_DEF_DLY: cfg_ff.def_dly <= toc_pkg::clamp16(
               pwdata[15:0], toc_pkg::DLY_MIN, toc_pkg::DLY_MAX);
            toc_pkg::OFS_RST_DLY: cfg_ff.rst_dly <= toc_pkg::clamp16(
               pwdata[15:0], toc_pkg::RDLY_MIN, toc_pkg::DLY_MAX);
            toc_pkg::OFS_IRQ_MASK: irq_mask_ff <= pwdata[toc_pkg::EV_W-1:0];
            default: ;
         endcase
      end
   end

   // Events: any edge of the phase pickup and general flags; only bits actually returned get cleared
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ev_prev_ff <= '0;
         irq_stat_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         ev_prev_ff <= ev_now;
         if (acc_done && !pwrite && paddr == toc_pkg::OFS_IRQ_STAT)
            irq_stat_ff <= (irq_stat_ff & ~prdata_ff[toc_pkg::EV_W-1:0])
                           | (ev_now ^ ev_prev_ff);
         else
            irq_stat_ff <= irq_stat_ff | (ev_now ^ ev_prev_ff);
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // Millisecond tick
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_ff <= 16'h0000;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (tick_cnt_ff == 16'(TICK_CYCLES - 1));
         tick_cnt_ff <= (tick_cnt_ff == 16'(TICK_CYCLES - 1)) ? 16'h0000 :
                        tick_cnt_ff + 16'h0001;
      end
   end

   // Shared restoring divider, one quotient bit per clock
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         div_num_ff <= '0;
         div_den_ff <= '0;
         div_quo_ff <= '0;
         div_rem_ff <= '0;
         div_cnt_ff <= 6'h00;
         div_done_ff <= 1'b0;
      end else begin
         div_done_ff <= (div_cnt_ff == 6'h01);
         if (div_go_ff) begin
            div_num_ff <= ld_num_ff;
            div_den_ff <= ld_den_ff;
            div_rem_ff <= '0;
            div_cnt_ff <= toc_pkg::DIV_STEPS;
         end else if (div_cnt_ff != 6'h00) begin
            div_num_ff <= {div_num_ff[46:0], 1'b0};
            div_cnt_ff <= div_cnt_ff - 6'h01;
            if (rem_sh >= div_den_ff) begin
               div_rem_ff <= rem_sh - div_den_ff;
               div_quo_ff <= {div_quo_ff[46:0], 1'b1};
            end else begin
               div_rem_ff <= rem_sh;
               div_quo_ff <= {div_quo_ff[46:0], 1'b0};
            end
         end
      end
   end

   // Delay sequencer: each tick recomputes operate and reset times per phase
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         seq_ff <= toc_pkg::SQ_IDLE;
         ph_ff <= 2'h0;
         ratio_ff <= 16'h0000;
         div_go_ff <= 1'b0;
         ld_num_ff <= '0;
         ld_den_ff <= '0;
         for (int p = 0; p < 3; p++) begin
            op_dly_ff[p] <= toc_pkg::DLY_RST;
            rst_dly_ff[p] <= toc_pkg::RDLY_RST;
         end
      end else begin
         div_go_ff <= 1'b0;
         case (seq_ff)
            toc_pkg::SQ_IDLE: begin
               ph_ff <= 2'h0;
               if (tick_ff) seq_ff <= toc_pkg::SQ_RATIO;
            end
            toc_pkg::SQ_RATIO: begin
               if (cfg_ff.mode == toc_pkg::TOC_DEFINITE) begin
                  op_dly_ff[ph_ff] <= cfg_ff.def_dly;
                  seq_ff <= (ph_ff == 2'h2) ? toc_pkg::SQ_IDLE :
                            toc_pkg::SQ_RATIO;
                  ph_ff <= ph_ff + 2'h1;
               end else if (cfg_ff.mode == toc_pkg::TOC_OFF) begin
                  seq_ff <= toc_pkg::SQ_IDLE;
               end else begin
                  ld_num_ff <= {24'h0, meas[ph_ff], 8'h00};
                  ld_den_ff <= {32'h0, cfg_ff.start};
                  div_go_ff <= 1'b1;
                  seq_ff <= toc_pkg::SQ_RDIV;
               end
            end
            toc_pkg::SQ_RDIV: begin
               if (div_done_ff) begin
                  ratio_ff <= (div_quo_ff > 48'(toc_pkg::RATIO_CLAMP)) ?
                              toc_pkg::RATIO_CLAMP : div_quo_ff[15:0];
                  seq_ff <= toc_pkg::SQ_CURVE;
               end
            end
            toc_pkg::SQ_CURVE: begin
               if (ratio_ff == toc_pkg::RATIO_ONE ||
                   (ratio_ff < toc_pkg::RATIO_ONE && !is_ansi)) begin
                  seq_ff <= (ph_ff == 2'h2) ? toc_pkg::SQ_IDLE :
                            toc_pkg::SQ_RATIO;
                  ph_ff <= ph_ff + 2'h1;
               end else begin
                  ld_num_ff <= (ratio_ff > toc_pkg::RATIO_ONE) ?
                     {8'h00, crv.k, 16'h0000} :
                     {8'h00, crv.kr, 16'h0000};
                  ld_den_ff <= {16'h0, den_q16};
                  div_go_ff <= 1'b1;
                  seq_ff <= toc_pkg::SQ_TDIV;
               end
            end
            toc_pkg::SQ_TDIV: begin
               if (div_done_ff) begin
                  if (ratio_ff > toc_pkg::RATIO_ONE)
                     op_dly_ff[ph_ff] <= (t_ms > cfg_ff.min_dly) ? t_ms :
                                         cfg_ff.min_dly;
                  else
                     rst_dly_ff[ph_ff] <= t_ms;
                  seq_ff <= (ph_ff == 2'h2) ? toc_pkg::SQ_IDLE :
                            toc_pkg::SQ_RATIO;
                  ph_ff <= ph_ff + 2'h1;
               end
            end
            default: seq_ff <= toc_pkg::SQ_IDLE;
         endcase
      end
   end

   // Pickup comparators; equality holds the previous state
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pick_ff <= 3'h0;
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (!active) pick_ff[p] <= 1'b0;
            else if (meas[p] > cfg_ff.start) pick_ff[p] <= 1'b1;
            else if (meas[p] < cfg_ff.start) pick_ff[p] <= 1'b0;
         end
      end
   end

   // Operate and reset timers; a held count lets a repeat fault trip sooner
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         for (int p = 0; p < 3; p++) begin
            op_cnt_ff[p] <= 16'h0000;
            rst_cnt_ff[p] <= 16'h0000;
         end
      end else begin
         for (int p = 0; p < 3; p++) begin
            if (!active) begin
               op_cnt_ff[p] <= 16'h0000;
               rst_cnt_ff[p] <= 16'h0000;
            end else if (tick_ff) begin
               if (pick_ff[p]) begin
                  rst_cnt_ff[p] <= 16'h0000;
                  if (op_cnt_ff[p] < op_dly_ff[p])
                     op_cnt_ff[p] <= op_cnt_ff[p] + 16'h0001;
               end else if (op_cnt_ff[p] != 16'h0000) begin
                  if ({1'b0, rst_cnt_ff[p]} + 17'h00001 >=
                      {1'b0, rst_lim[p]}) begin
                     op_cnt_ff[p] <= 16'h0000;
                     rst_cnt_ff[p] <= 16'h0000;
                  end else begin
                     rst_cnt_ff[p] <= rst_cnt_ff[p] + 16'h0001;
                  end
               end
            end
         end
      end
   end

   // Trip and general flags
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         trip_ff <= 3'h0;
         gen_pick_ff <= 1'b0;
         gen_trip_ff <= 1'b0;
      end else begin
         for (int p = 0; p < 3; p++)
            trip_ff[p] <= active && pick_ff[p] &&
                          (op_cnt_ff[p] >= op_dly_ff[p]);
         gen_pick_ff <= active && (|pick_ff);
         gen_trip_ff <= active && (|trip_ff);
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign phase1_pickup = pick_ff[0];
   assign phase2_pickup = pick_ff[1];
   assign phase3_pickup = pick_ff[2];
   assign phase1_trip = trip_ff[0];
   assign phase2_trip = trip_ff[1];
   assign phase3_trip = trip_ff[2];
   assign any_phase_pickup = gen_pick_ff;
   assign any_phase_trip = gen_trip_ff;
   assign irq = irq_ff;
endmodule : toc_core

// file: verilog/toc_pkg.sv
package toc_pkg;
   // Timing base: protection delays advance on a one millisecond tick
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_TMS = 8'h08;
   localparam logic [7:0] OFS_MIN_DLY = 8'h0C;
   localparam logic [7:0] OFS_DEF_DLY = 8'h10;
   localparam logic [7:0] OFS_RST_DLY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;

   // Setting ranges and reset values (percent, hundredths, milliseconds)
   localparam logic [15:0] START_MIN = 16'h000A;
   localparam logic [15:0] START_MAX = 16'h0BB8;
   localparam logic [15:0] START_RST = 16'h00C8;
   localparam logic [15:0] TMS_MIN = 16'h0005;
   localparam logic [15:0] TMS_MAX = 16'h05DC;
   localparam logic [15:0] TMS_RST = 16'h00C8;
   localparam logic [15:0] DLY_MIN = 16'h0028;
   localparam logic [15:0] DLY_MAX = 16'hEA60;
   localparam logic [15:0] DLY_RST = 16'h0064;
   localparam logic [15:0] RDLY_MIN = 16'h003C;
   localparam logic [15:0] RDLY_RST = 16'h0064;

   // Status and interrupt field layout
   localparam int unsigned EV_W = 5;
   localparam int unsigned ST_TRIP_LSB = 3;
   localparam int unsigned ST_GPICK = 6;
   localparam int unsigned ST_GTRIP = 7;

   // Fixed point: ratio in Q8, curve denominator in Q16
   localparam logic [15:0] RATIO_ONE = 16'h0100;
   localparam logic [15:0] RATIO_CLAMP = 16'h1400;
   localparam logic [31:0] Q16_ONE = 32'h0001_0000;
   localparam logic [31:0] LN_SCALE = 32'h0000_038D;
   localparam logic [63:0] RECIP_1000 = 64'h0000_0000_0000_0419;
   localparam int unsigned RECIP_SHIFT = 20;
   localparam logic [5:0] DIV_STEPS = 6'h30;

   typedef enum logic [3:0] {
      TOC_OFF = 4'h0, TOC_DEFINITE = 4'h1, TOC_IEC_INV = 4'h2,
      TOC_IEC_VERY = 4'h3, TOC_IEC_EXT = 4'h4, TOC_IEC_LONG = 4'h5,
      TOC_ANSI_INV = 4'h6, TOC_ANSI_MOD = 4'h7, TOC_ANSI_VERY = 4'h8,
      TOC_ANSI_EXT = 4'h9, TOC_ANSI_LONG = 4'hA, TOC_ANSI_LVERY = 4'hB,
      TOC_ANSI_LEXT = 4'hC
   } toc_mode_t;

   typedef enum logic [2:0] {
      SQ_IDLE = 3'b000, SQ_RATIO = 3'b001, SQ_RDIV = 3'b010,
      SQ_CURVE = 3'b011, SQ_TDIV = 3'b100
   } toc_seq_t;

   typedef struct packed {
      toc_mode_t mode;
      logic [15:0] start;
      logic [15:0] tms;
      logic [15:0] min_dly;
      logic [15:0] def_dly;
      logic [15:0] rst_dly;
   } toc_cfg_t;

   localparam toc_cfg_t CFG_RST = '{mode: TOC_OFF, start: START_RST,
      tms: TMS_RST, min_dly: DLY_RST, def_dly: DLY_RST, rst_dly: RDLY_RST};

   // Curve constants in 0.1 ms; alpha code 0 = 0.02, 1 = 1, 2 = 2
   typedef struct packed {
      logic [23:0] k;
      logic [15:0] c;
      logic [23:0] kr;
      logic [1:0] alpha;
   } toc_curve_t;

   function automatic toc_curve_t curve_of(input toc_mode_t m);
      case (m)
         TOC_IEC_INV: curve_of = '{24'h000578, 16'h0000, 24'h0, 2'h0};
         TOC_IEC_VERY: curve_of = '{24'h020F58, 16'h0000, 24'h0, 2'h1};
         TOC_IEC_EXT: curve_of = '{24'h0C3500, 16'h0000, 24'h0, 2'h2};
         TOC_IEC_LONG: curve_of = '{24'h124F80, 16'h0000, 24'h0, 2'h1};
         TOC_ANSI_INV: curve_of = '{24'h000056, 16'h00B9, 24'h0011F8, 2'h0};
         TOC_ANSI_MOD: curve_of = '{24'h000203, 16'h0474, 24'h00BD74, 2'h0};
         TOC_ANSI_VERY: curve_of = '{24'h02FE04, 16'h132E, 24'h034BC0, 2'h2};
         TOC_ANSI_EXT: curve_of = '{24'h044D90, 16'h04C1, 24'h0470B8, 2'h2};
         TOC_ANSI_LONG: curve_of = '{24'h00035C, 16'h073A, 24'h00B3B0, 2'h0};
         TOC_ANSI_LVERY: curve_of = '{24'h045B3C, 16'h1BD0, 24'h020DC8, 2'h2};
         TOC_ANSI_LEXT: curve_of = '{24'h09C6BC, 16'h09C4, 24'h0493E0, 2'h2};
         default: curve_of = '{24'h0, 16'h0, 24'h0, 2'h0};
      endcase
   endfunction : curve_of

   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp16
endpackage : toc_pkg

// file: tb/toc_front_end.sv
`timescale 1ns/1ps
// Measurement front end: one registered RMS estimate per phase
module toc_front_end (
   input wire logic core_clk, // Clock
   input wire logic [2:0][15:0] level, // Commanded current
   output logic [2:0][15:0] rms // RMS to the block
);
   // One clock of latency, as a settled filter output would have
   always_ff @(posedge core_clk) begin
      rms <= level;
   end
endmodule : toc_front_end

// file: tb/toc_core_sva.sv
`timescale 1ns/1ps
module toc_core_sva #(
   parameter int unsigned TICK_CYCLES = 40
) (
   input wire logic core_clk, // Clock
   input wire logic resetn, // Reset, low
   input wire logic inhibit_input, // Disable
   input wire logic psel, // Select
   input wire logic penable, // Access
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic phase1_pickup, // Start 1
   input wire logic phase2_pickup, // Start 2
   input wire logic phase3_pickup, // Start 3
   input wire logic phase1_trip, // Trip 1
   input wire logic phase2_trip, // Trip 2
   input wire logic phase3_trip, // Trip 3
   input wire logic any_phase_pickup, // General start
   input wire logic any_phase_trip // General trip
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // General flags are registered ORs of the phase flags
   // Inhibit gates the general flags at the same edge as the phase flags
   a_gen_pick_or: assert property (1'b1 |=> any_phase_pickup ==
      ($past(phase1_pickup | phase2_pickup | phase3_pickup) &&
      !$past(inhibit_input)))
      else $error("general pickup mismatch");
   a_gen_trip_or: assert property (1'b1 |=> any_phase_trip ==
      ($past(phase1_trip | phase2_trip | phase3_trip) &&
      !$past(inhibit_input)))
      else $error("general trip mismatch");
   // A trip never stands without a pickup one clock before
   a_trip_needs_pick: assert property (
      ({phase3_trip, phase2_trip, phase1_trip} & ~$past({phase3_pickup,
      phase2_pickup, phase1_pickup})) == 3'b000)
      else $error("trip without pickup");
   a_trip_holds: assert property (
      phase1_trip && phase1_pickup && !inhibit_input |=> phase1_trip)
      else $error("trip dropped early");
   a_inhibit_clears: assert property (inhibit_input |=>
      {phase1_pickup, phase2_pickup, phase3_pickup, phase1_trip,
      phase2_trip, phase3_trip} == 6'b000000)
      else $error("inhibit ignored");
   a_pick_not_inh: assert property (
      $rose(phase1_pickup) |-> !$past(inhibit_input))
      else $error("pickup while inhibited");
   // Bus answers after exactly one wait state, ready for one cycle
   a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("wait state count wrong");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
endmodule : toc_core_sva
bind toc_core toc_core_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (.core_clk,
   .resetn, .inhibit_input, .psel, .penable, .pready, .pslverr,
   .phase1_pickup, .phase2_pickup, .phase3_pickup, .phase1_trip,
   .phase2_trip, .phase3_trip, .any_phase_pickup, .any_phase_trip);

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   localparam int TC = 40;
   logic core_clk = 0, resetn = 0, inh = 0, psel = 0, penable = 0;
   logic pwrite = 0, pready, pslverr, err, irq, gpk, gtr;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [2:0] pk, tr;
   logic [2:0][15:0] lvl = '0, rms;
   int num_errors = 0, n_checks = 0, p, n;
   toc_front_end u_fe (.core_clk(core_clk), .level(lvl), .rms(rms));
   toc_core #(.TICK_CYCLES(TC)) u_dut (.core_clk(core_clk),
      .resetn(resetn), .phase1_fundamental_rms(rms[0]),
      .phase2_fundamental_rms(rms[1]), .phase3_fundamental_rms(rms[2]),
      .inhibit_input(inh), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .phase1_pickup(pk[0]), .phase2_pickup(pk[1]),
      .phase3_pickup(pk[2]), .phase1_trip(tr[0]), .phase2_trip(tr[1]),
      .phase3_trip(tr[2]), .any_phase_pickup(gpk), .any_phase_trip(gtr),
      .irq(irq));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      n_checks++;
      if (g !== x) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
   endtask : chk
   // Setup, access, then release at the edge that samples ready high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) num_errors++;
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [31:0] dflt(input int i);
      dflt = (i == 0) ? 32'h0 : ((i < 3) ? 32'h0000_00C8 : 32'h0000_0064);
   endfunction : dflt
   // Definite trip lands DEF_DLY ticks after pickup, give or take a tick
   function automatic logic in_win(input int c, input int ms);
      in_win = (c > ms * TC - TC - 8) && (c < ms * TC + TC + 8);
   endfunction : in_win
   task automatic settle(input int c);
      repeat (c) @(negedge core_clk);
   endtask : settle
   task automatic wrap_up;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      #(25 * 30000);
      num_errors++;
      wrap_up();
   end
   initial begin
      void'($urandom(32'hEA37D63E));
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(q, dflt(i));
      end
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, toc_pkg::OFS_START, 32'h0000_0005);
      apb(1'b0, toc_pkg::OFS_START, 32'h0);
      chk(q, 32'h0000_000A);
      @(posedge core_clk);
      lvl <= {3{16'h0BB8}};
      settle(6);
      chk(pk, 3'b000);
      // Drop the current first so enabling the mode starts nothing
      @(posedge core_clk);
      lvl <= '0;
      apb(1'b1, toc_pkg::OFS_START, 32'h0000_0064);
      apb(1'b1, toc_pkg::OFS_DEF_DLY, 32'h0000_0028);
      apb(1'b1, toc_pkg::OFS_IRQ_MASK, 32'h0000_001F);
      apb(1'b1, toc_pkg::OFS_MODE, 32'h0000_0001);
      settle(6);
      apb(1'b0, toc_pkg::OFS_IRQ_STAT, 32'h0);
      repeat (2) begin
         p = $urandom_range(2, 0);
         @(posedge core_clk);
         lvl[p] <= 16'($urandom_range(1099, 101));
         settle(4);
         chk(pk, 3'b001 << p);
         chk(gpk, 1'b1);
         n = 0;
         while (tr[p] !== 1'b1 && n < 4000) begin
            @(negedge core_clk);
            n++;
         end
         chk(in_win(n, 40), 1'b1);
         settle(2);
         chk({gtr, irq}, 2'b11);
         @(posedge core_clk);
         lvl[p] <= 16'h0064;
         settle(4);
         chk({pk[p], tr[p]}, 2'b11);
         @(posedge core_clk);
         lvl[p] <= 16'h0032;
         settle(4);
         chk({pk, tr}, 6'b0);
         settle(2 * TC);
         apb(1'b0, toc_pkg::OFS_IRQ_STAT, 32'h0);
         chk(q, (32'h1 << p) | 32'h18);
         settle(3);
         chk(irq, 1'b0);
      end
      // Extremely inverse IEC, five times start, TMS 0.05: 80/24*0.05 s
      apb(1'b1, toc_pkg::OFS_TMS, 32'h0000_0005);
      apb(1'b1, toc_pkg::OFS_MODE, 32'h0000_0004);
      lvl[0] <= 16'h01F4;
      n = 0;
      while (tr[0] !== 1'b1 && n < 9000) begin
         @(negedge core_clk);
         n++;
      end
      chk(n > 150 * TC && n < 183 * TC, 1'b1);
      @(posedge core_clk);
      lvl <= {3{16'h01F4}};
      settle(4);
      chk(pk, 3'b111);
      @(posedge core_clk);
      inh <= 1'b1;
      settle(3);
      chk({pk, tr, gpk}, 7'b0);
      wrap_up();
   end
endmodule : tb
